/* logic/eiem_pkg.sv */
// Constants for the extended interrupt enable mask block.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.
// Notes on behaviour
// - Bit 5 passes or blocks LIN request
// - Bit 4 gates comparator rising-edge request
// - Bit 3 gates comparator falling-edge request independently
// - Bit 2 masks all counter-array requests together
// - Bit 1 gates conversion-done flag request
// - Bit 0 gates window-compare request
package eiem_pkg;
    localparam int          EIEM_SRC_N     = 6;
    localparam int          EIEM_ADDR_W    = 8;
    localparam int          EIEM_DATA_W    = 32;
    localparam int          EIEM_MASK_W    = 8;

    // Bit positions of the mask, status, clear and enable registers
    localparam int          WINDOW_BIT     = 0;
    localparam int          CONV_DONE_BIT  = 1;
    localparam int          COUNTER_BIT    = 2;
    localparam int          CMP_FALL_BIT   = 3;
    localparam int          CMP_RISE_BIT   = 4;
    localparam int          LIN_BIT        = 5;

    // Register byte addresses
    localparam logic [7:0]  MASK_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;
    localparam logic [7:0]  CLEAR_OFS      = 8'h08;
    localparam logic [7:0]  IRQ_EN_OFS     = 8'h0c;
    localparam logic [7:0]  LEVEL_OFS      = 8'h10;

    // Reset values
    localparam logic [7:0]  MASK_RST       = 8'h00;
    localparam logic [5:0]  STATUS_RST     = 6'h00;
    localparam logic [5:0]  IRQ_EN_RST     = 6'h00;

    typedef enum logic [2:0] {
        EIEM_SEL_NONE   = 3'h0,
        EIEM_SEL_MASK   = 3'h1,
        EIEM_SEL_STATUS = 3'h2,
        EIEM_SEL_CLEAR  = 3'h3,
        EIEM_SEL_IRQ_EN = 3'h4,
        EIEM_SEL_LEVEL  = 3'h5
    } eiem_sel_t;
endpackage

/* logic/eiem_if.sv */
// Interface between the register block and the request gate.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface eiem_gate_if;
    import eiem_pkg::*;
    logic [EIEM_SRC_N-1:0] src_req;
    logic [EIEM_SRC_N-1:0] enable;
    logic [EIEM_SRC_N-1:0] delivered;

    modport regs (output src_req, output enable, input delivered);
    modport gate (input src_req, input enable, output delivered);
endinterface

/* logic/eiem_gate.sv */
// Registered per-source gate of peripheral requests.
// Assumes requests are levels from logic on pclk.
`timescale 1ns/1ps
module eiem_gate
    import eiem_pkg::*;
(
    // Clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // Gate signals
    eiem_gate_if.gate      gif
);
    logic [EIEM_SRC_N-1:0] next_delivered;

    genvar i;
    generate
        for (i = 0; i < EIEM_SRC_N; i++) begin : g_src
            // Request only read here, never cleared
            assign next_delivered[i] = gif.src_req[i] & gif.enable[i];
        end
    endgenerate

    // Registered delivery toward the processor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gif.delivered <= '0;
        end else begin
            gif.delivered <= next_delivered;
        end
    end
endmodule

/* logic/eiem_top.sv */
// Extended interrupt enable mask with APB registers and event interrupt.
// Assumes source requests are levels held by the sources until serviced.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module eiem_top
    import eiem_pkg::*;
(
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [EIEM_ADDR_W-1:0]  paddr,
    input  wire logic [EIEM_DATA_W-1:0]  pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [EIEM_DATA_W-1:0]  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Peripheral requests
    input  wire logic [EIEM_SRC_N-1:0]   src_req,
    // Processor side
    output logic      [EIEM_SRC_N-1:0]   cpu_irq_req,
    output logic                         irq
);
    eiem_gate_if gif ();

    logic [EIEM_MASK_W-1:0] mask_reg;
    logic [EIEM_SRC_N-1:0]  status;
    logic [EIEM_SRC_N-1:0]  irq_en;
    logic [EIEM_SRC_N-1:0]  delivered_d;
    logic [EIEM_SRC_N-1:0]  rise_evt;
    logic [EIEM_SRC_N-1:0]  clr_vec;
    logic [EIEM_DATA_W-1:0] next_prdata;
    logic                   access;
    logic                   wr_en;
    logic                   lane0;
    eiem_sel_t              sel;

    // Address decode shared by read and write
    function automatic eiem_sel_t decode(input logic [EIEM_ADDR_W-1:0] a);
        unique case (a)
            MASK_OFS:   decode = EIEM_SEL_MASK;
            STATUS_OFS: decode = EIEM_SEL_STATUS;
            CLEAR_OFS:  decode = EIEM_SEL_CLEAR;
            IRQ_EN_OFS: decode = EIEM_SEL_IRQ_EN;
            LEVEL_OFS:  decode = EIEM_SEL_LEVEL;
            default:    decode = EIEM_SEL_NONE;
        endcase
    endfunction

    // Write strobe of one register, byte lane 0 only
    function automatic logic wr_hit(input eiem_sel_t cur,
                                    input eiem_sel_t target,
                                    input logic      we,
                                    input logic      lane);
        wr_hit = we & lane & (cur == target);
    endfunction

    assign sel     = decode(paddr);
    assign access  = psel & penable;
    assign wr_en   = access & pwrite;
    assign lane0   = pstrb[0];
    assign pready  = 1'b1;
    assign pslverr = access & ((sel == EIEM_SEL_NONE)
                     | (pwrite & (sel == EIEM_SEL_STATUS))
                     | (pwrite & (sel == EIEM_SEL_LEVEL))
                     | (!pwrite & (sel == EIEM_SEL_CLEAR)));

    // Mask register, upper two bits reserved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RST;
        end else if (wr_hit(sel, EIEM_SEL_MASK, wr_en, lane0)) begin
            mask_reg <= {2'b00, pwdata[EIEM_SRC_N-1:0]};
        end
    end

    // Per-source enables into the gate
    assign gif.src_req                = src_req;
    assign gif.enable[LIN_BIT]        = mask_reg[LIN_BIT];
    assign gif.enable[CMP_RISE_BIT]   = mask_reg[CMP_RISE_BIT];
    assign gif.enable[CMP_FALL_BIT]   = mask_reg[CMP_FALL_BIT];
    assign gif.enable[COUNTER_BIT]    = mask_reg[COUNTER_BIT];
    assign gif.enable[CONV_DONE_BIT]  = mask_reg[CONV_DONE_BIT];
    assign gif.enable[WINDOW_BIT]     = mask_reg[WINDOW_BIT];

    eiem_gate u_gate (
        .pclk    (pclk),
        .presetn (presetn),
        .gif     (gif)
    );

    assign cpu_irq_req = gif.delivered;

    // Delivery edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delivered_d <= '0;
        end else begin
            delivered_d <= gif.delivered;
        end
    end

    assign rise_evt = gif.delivered & ~delivered_d;
    assign clr_vec  = wr_hit(sel, EIEM_SEL_CLEAR, wr_en, lane0) ?
                      pwdata[EIEM_SRC_N-1:0] : '0;

    // Sticky status, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RST;
        end else begin
            status <= (status & ~clr_vec) | rise_evt;
        end
    end

    // Interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= IRQ_EN_RST;
        end else if (wr_hit(sel, EIEM_SEL_IRQ_EN, wr_en, lane0)) begin
            irq_en <= pwdata[EIEM_SRC_N-1:0];
        end
    end

    assign irq = |(status & irq_en);

    // Read word of the addressed register
    always_comb begin
        next_prdata = '0;
        unique case (sel)
            EIEM_SEL_MASK:   next_prdata[EIEM_MASK_W-1:0] = mask_reg;
            EIEM_SEL_STATUS: next_prdata[EIEM_SRC_N-1:0]  = status;
            EIEM_SEL_IRQ_EN: next_prdata[EIEM_SRC_N-1:0]  = irq_en;
            EIEM_SEL_LEVEL:  next_prdata[EIEM_SRC_N-1:0]  = src_req;
            EIEM_SEL_CLEAR:  next_prdata = '0;
            EIEM_SEL_NONE:   next_prdata = '0;
        endcase
    end

    // Read data caught at the setup edge, zero otherwise
    // An event after that edge shows on the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end else begin
            prdata <= '0;
        end
    end
endmodule

/* dv/eiem_props.sv */
// Checker of the gated request outputs.
// Assumes binding onto eiem_top, one pclk domain.
`timescale 1ns/1ps
module eiem_props
    import eiem_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [EIEM_ADDR_W-1:0] paddr,
    input wire logic [EIEM_DATA_W-1:0] pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [EIEM_SRC_N-1:0]  src_req,
    input wire logic [EIEM_SRC_N-1:0]  cpu_irq_req
);
    logic [5:0] m;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m <= 6'h00;
        end else if (psel && penable && pwrite && paddr == MASK_OFS && pstrb[0]) begin
            m <= pwdata[5:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_LIN: assert property (cpu_irq_req[5] == $past(src_req[5] & m[5])) else $error("lin");
    AST_RISE: assert property (cpu_irq_req[4] == $past(src_req[4] & m[4])) else $error("rise");
    AST_FALL: assert property (cpu_irq_req[3] == $past(src_req[3] & m[3])) else $error("fall");
    AST_CNT: assert property (cpu_irq_req[2] == $past(src_req[2] & m[2])) else $error("cnt");
    AST_DONE: assert property (cpu_irq_req[1] == $past(src_req[1] & m[1])) else $error("done");
    AST_WIN: assert property (cpu_irq_req[0] == $past(src_req[0] & m[0])) else $error("win");
    AST_HELD: assert property ($rose(m[2]) && src_req[2] |=> cpu_irq_req[2]) else $error("held");
    cover property (cpu_irq_req == 6'h3f);
    cover property ($rose(m[2]) && src_req[2]);
    cover property ($fell(cpu_irq_req[5]));
endmodule
bind eiem_top eiem_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .src_req, .cpu_irq_req);

/* dv/eiem_src_model.sv */
// Peripheral sources holding pending request levels.
// Assumes set and clear pulses from the bench on pclk.
`timescale 1ns/1ps
module eiem_src_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [5:0] set_req,
    input  wire logic [5:0] clr_req,
    output logic      [5:0] src_req
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_req <= 6'h00;
        end else begin
            src_req <= (src_req | set_req) & ~clr_req;
        end
    end
endmodule

/* dv/tb_extended_interrupt_enable_mask.sv */
// Bench of the mask block with random masks and sources.
// Assumes zero wait APB answers within a bounded wait.
`timescale 1ns/1ps
module tb_extended_interrupt_enable_mask;
    import eiem_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h00017b1c;
    logic [3:0]  pstrb = 4'hf;
    logic [5:0]  src_req, cpu_irq_req, es = 6'h00, set = 6'h00, clr = 6'h00, e;
    int fails = 0, check_count = 0, i;
    eiem_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .src_req, .cpu_irq_req, .irq);
    eiem_src_model i_src (.pclk, .presetn, .set_req(set), .clr_req(clr), .src_req);
    initial forever #25 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [5:0] exp_gate(input logic [5:0] p, input logic [5:0] m);
        return p & m;
    endfunction
    task automatic complete_run();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) chk("pready", pready, 1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic src(input logic [5:0] s, input logic [5:0] c);
        set <= s;
        clr <= c;
        es = (es | s) & ~c;
        @(posedge pclk);
        set <= 6'h00;
        clr <= 6'h00;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, MASK_OFS, 0);
        chk("mask rst", rd, {24'h000000, MASK_RST});
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            apb(1, MASK_OFS, rnd);
            src(rnd[13:8], rnd[21:16]);
            e = exp_gate(es, rnd[5:0]);
            chk("gate hi", cpu_irq_req[5:3], e[5:3]);
            chk("gate lo", cpu_irq_req[2:0], e[2:0]);
        end
        apb(1, MASK_OFS, 0);
        src(6'h3f, 6'h00);
        chk("masked", cpu_irq_req, 0);
        apb(0, LEVEL_OFS, 0);
        chk("pending", rd, 32'h3f);
        apb(1, IRQ_EN_OFS, 32'h3f);
        apb(1, MASK_OFS, 32'h3f);
        repeat (2) @(posedge pclk);
        chk("unmasked", cpu_irq_req, 6'h3f);
        chk("irq", irq, 1);
        pstrb <= 4'he;
        apb(1, MASK_OFS, 32'h00);
        pstrb <= 4'hf;
        apb(0, MASK_OFS, 0);
        chk("lane0", rd, 32'h3f);
        apb(1, IRQ_EN_OFS, 0);
        chk("irq off", irq, 0);
        apb(1, CLEAR_OFS, 32'h3f);
        apb(0, STATUS_OFS, 0);
        chk("status", rd, 0);
        apb(1, STATUS_OFS, 32'h3f);
        chk("ro err", er, 1);
        apb(0, STATUS_OFS, 0);
        chk("ro", rd, 0);
        apb(0, 8'h20, 0);
        chk("unmapped", {rd[30:0], er}, 1);
        complete_run();
    end
endmodule
